// ---- hdl/tws_master.sv ----
// Bus master for a two-wire serial register slave with 16-bit addresses.
// Assumes a pull-up on the data line outside; the slave never holds the
// clock, so the clock is driven push-pull and never read back.
`timescale 1ns/1ns
module tws_master #(
  parameter int QUARTER = tws_pkg::QUARTER_CYC
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Command request
  input wire logic i_cmd_valid,
  input wire tws_pkg::tws_cmd_s i_cmd,
  output logic o_cmd_ready,
  // Write data stream
  input wire logic i_wdata_valid,
  input wire logic [7:0] i_wdata,
  output logic o_wdata_ready,
  // Read data
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // Status
  output logic o_done,
  output logic o_nack,
  output logic o_busy,
  // Bus pins
  output logic o_serial_clock,
  input wire logic i_serial_bus_line,
  output logic o_serial_bus_line,
  output logic o_serial_bus_line_oe
);

  tws_pkg::tws_state_s s;
  tws_pkg::tws_state_s n;
  logic tick;
  logic active;

  // Quarter-bit timebase: four quarters make one serial clock period
  tws_tick #(
    .DIV(QUARTER)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .o_tick(tick)
  );

  // Next state; all pin levels are derived from it and registered
  always_comb begin
    n = s;
    active = 1'b0;
    n.sda_s1 = i_serial_bus_line;
    n.sda_s2 = s.sda_s1;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    unique case (s.st)
      tws_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          n.kind = i_cmd.kind;
          n.reg_addr = i_cmd.reg_addr;
          n.left = i_cmd.len;
          n.nack = 1'b0;
          // Pick the slave address the device is strapped or set to
          unique case (i_cmd.sel)
            tws_pkg::SEL_ALT: n.dev = tws_pkg::DEV_ADDR_ALT;
            tws_pkg::SEL_PROG: n.dev = i_cmd.prog_addr;
            default: n.dev = tws_pkg::DEV_ADDR_DEFAULT;
          endcase
          // A current read goes straight to the read address byte
          if (i_cmd.kind == tws_pkg::KIND_READ_CUR) begin
            n.step = tws_pkg::STEP_SLA_R;
          end else begin
            n.step = tws_pkg::STEP_SLA_W;
          end
          // Bus is idle high, so begin at the high half of the start
          n.st = tws_pkg::ST_START;
          n.ph = 2'h2;
          n.bitn = 4'h0;
        end
      end
      tws_pkg::ST_WAIT_W: begin
        // Clock stays high while the source has nothing to send
        if (i_wdata_valid) begin
          n.shreg = i_wdata;
          n.st = tws_pkg::ST_ARM;
        end
      end
      tws_pkg::ST_ARM: begin
        // Wait for a quarter edge so the first low phase is whole
        if (tick) begin
          n.st = tws_pkg::ST_TX;
          n.bitn = 4'h0;
          n.ph = 2'h0;
        end
      end
      tws_pkg::ST_START: begin
        if (tick) begin
          if (s.ph != 2'h3) begin
            n.ph = s.ph + 2'h1;
          end else begin
            // Address and direction byte follows the start
            n.ph = 2'h0;
            n.bitn = 4'h0;
            n.st = tws_pkg::ST_TX;
            if (s.step == tws_pkg::STEP_SLA_R) begin
              n.shreg = {s.dev, tws_pkg::DIR_READ};
            end else begin
              n.shreg = {s.dev, tws_pkg::DIR_WRITE};
            end
          end
        end
      end
      tws_pkg::ST_TX: begin
        if (tick) begin
          if (s.ph != 2'h3) begin
            n.ph = s.ph + 2'h1;
          end else if (s.bitn != tws_pkg::ACK_SLOT) begin
            // Next bit, MSB first, shifted at the end of the high half
            n.ph = 2'h0;
            n.shreg = {s.shreg[6:0], 1'b0};
            n.bitn = s.bitn + 4'h1;
          end else if (s.sda_s2) begin
            // Line left high in the slot: no slave answered
            n.ph = 2'h0;
            n.nack = 1'b1;
            n.st = tws_pkg::ST_STOP;
          end else begin
            n.ph = 2'h0;
            n.bitn = 4'h0;
            unique case (s.step)
              tws_pkg::STEP_SLA_W: begin
                n.step = tws_pkg::STEP_AHI;
                n.shreg = s.reg_addr[15:8];
              end
              tws_pkg::STEP_AHI: begin
                n.step = tws_pkg::STEP_ALO;
                n.shreg = s.reg_addr[7:0];
              end
              tws_pkg::STEP_ALO: begin
                if (s.kind == tws_pkg::KIND_READ_RND) begin
                  // Dummy write done; restart with the read address
                  n.step = tws_pkg::STEP_SLA_R;
                  n.st = tws_pkg::ST_START;
                end else begin
                  n.step = tws_pkg::STEP_WDAT;
                  n.st = tws_pkg::ST_WAIT_W;
                end
              end
              tws_pkg::STEP_WDAT: begin
                // More bytes go to successive register addresses
                if (s.left == '0) begin
                  n.st = tws_pkg::ST_STOP;
                end else begin
                  n.left = s.left - tws_pkg::LEN_W'(1);
                  n.st = tws_pkg::ST_WAIT_W;
                end
              end
              tws_pkg::STEP_SLA_R: begin
                n.step = tws_pkg::STEP_RDAT;
                n.st = tws_pkg::ST_RX;
              end
              default: begin
                n.st = tws_pkg::ST_STOP;
              end
            endcase
          end
        end
      end
      tws_pkg::ST_RX: begin
        if (tick) begin
          if (s.ph != 2'h3) begin
            n.ph = s.ph + 2'h1;
          end else if (s.bitn != tws_pkg::ACK_SLOT) begin
            // Sample at the end of the high half, when it is stable
            n.ph = 2'h0;
            n.shreg = {s.shreg[6:0], s.sda_s2};
            n.bitn = s.bitn + 4'h1;
            if (s.bitn == tws_pkg::LAST_DATA_BIT) begin
              n.rdata = {s.shreg[6:0], s.sda_s2};
              n.rvalid = 1'b1;
            end
          end else if (s.left == '0) begin
            // Last byte was refused, so the stop follows
            n.ph = 2'h0;
            n.st = tws_pkg::ST_STOP;
          end else begin
            // The slave moves its pointer on by itself
            n.ph = 2'h0;
            n.bitn = 4'h0;
            n.left = s.left - tws_pkg::LEN_W'(1);
          end
        end
      end
      tws_pkg::ST_STOP: begin
        if (tick) begin
          if (s.ph != 2'h3) begin
            n.ph = s.ph + 2'h1;
          end else begin
            n.ph = 2'h0;
            n.st = tws_pkg::ST_IDLE;
            n.done = 1'b1;
          end
        end
      end
      default: begin
        n.st = tws_pkg::ST_IDLE;
      end
    endcase

    // Pin levels: clock low in quarters 0 and 1 of every bit
    active = (n.st == tws_pkg::ST_START) || (n.st == tws_pkg::ST_TX) ||
             (n.st == tws_pkg::ST_RX) || (n.st == tws_pkg::ST_STOP);
    n.scl_low = active && (n.ph < 2'h2);
    n.busy = (n.st != tws_pkg::ST_IDLE);
    if (!active) begin
      n.sda_drv = 1'b0;
    end else if (n.ph == 2'h0) begin
      // Hold data a quarter after the clock falls to avoid a false edge
      n.sda_drv = s.sda_drv;
    end else begin
      unique case (n.st)
        tws_pkg::ST_START: begin
          n.sda_drv = (n.ph == 2'h3);
        end
        tws_pkg::ST_TX: begin
          // Release in the slot so the slave can answer
          if (n.bitn == tws_pkg::ACK_SLOT) begin
            n.sda_drv = 1'b0;
          end else begin
            n.sda_drv = ~n.shreg[7];
          end
        end
        tws_pkg::ST_RX: begin
          // Acknowledge only while more bytes are wanted
          n.sda_drv = (n.bitn == tws_pkg::ACK_SLOT) &&
                      (n.left != '0);
        end
        default: begin
          // Stop: low through the clock rise, then released
          n.sda_drv = (n.ph != 2'h3);
        end
      endcase
    end
  end

  // Register all state, frozen while the enable is low
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= n;
    end
  end

  // Handshakes are combinational from state
  assign o_cmd_ready = (s.st == tws_pkg::ST_IDLE);
  assign o_wdata_ready = (s.st == tws_pkg::ST_WAIT_W);

  // Data and status straight from flip-flops
  assign o_rdata = s.rdata;
  assign o_rdata_valid = s.rvalid;
  assign o_done = s.done;
  assign o_nack = s.nack;
  assign o_busy = s.busy;

  // Clock is never released to the slave, which cannot stretch it
  assign o_serial_clock = ~s.scl_low;
  // Open drain data: only ever pulled low
  assign o_serial_bus_line = 1'b0;
  assign o_serial_bus_line_oe = s.sda_drv;

endmodule

// ---- common/tws_pkg.sv ----
// Shared constants and types for the two-wire register bus master.
// Assumes a 25 MHz system clock; the serial clock is made from it here.
package tws_pkg;

  // System clock period and serial clock quarter period
  localparam int MCLK_NS = 40;
  localparam int QUARTER_NS = 2500;
  // Least time, so round the count up
  localparam int QUARTER_CYC = (QUARTER_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int TICK_W = 12;

  // Slave address choices seen from the bus side
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h36;
  localparam logic [6:0] DEV_ADDR_ALT = 7'h37;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Byte framing: bits 0..7 carry data, bit 8 is the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Width of the byte count carried by a command
  localparam int LEN_W = 8;

  typedef enum logic [1:0] {
    KIND_WRITE = 2'h0,
    KIND_READ_RND = 2'h1,
    KIND_READ_CUR = 2'h2
  } tws_kind_e;

  typedef enum logic [1:0] {
    SEL_DEFAULT = 2'h0,
    SEL_ALT = 2'h1,
    SEL_PROG = 2'h2
  } tws_sel_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_TX = 3'h2,
    ST_RX = 3'h3,
    ST_STOP = 3'h4,
    ST_WAIT_W = 3'h5,
    ST_ARM = 3'h6
  } tws_st_e;

  typedef enum logic [2:0] {
    STEP_SLA_W = 3'h0,
    STEP_AHI = 3'h1,
    STEP_ALO = 3'h2,
    STEP_WDAT = 3'h3,
    STEP_SLA_R = 3'h4,
    STEP_RDAT = 3'h5
  } tws_step_e;

  // One request: len is the byte count minus one
  typedef struct packed {
    tws_kind_e kind;
    tws_sel_e sel;
    logic [6:0] prog_addr;
    logic [15:0] reg_addr;
    logic [LEN_W-1:0] len;
  } tws_cmd_s;

  typedef struct packed {
    tws_st_e st;
    tws_step_e step;
    tws_kind_e kind;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [6:0] dev;
    logic [15:0] reg_addr;
    logic [LEN_W-1:0] left;
    logic [7:0] rdata;
    logic rvalid;
    logic done;
    logic nack;
    logic busy;
    logic scl_low;
    logic sda_drv;
    logic sda_s1;
    logic sda_s2;
  } tws_state_s;

  typedef struct packed {
    logic [TICK_W-1:0] count;
    logic tick;
  } tws_tick_s;

endpackage

// ---- hdl/tws_tick.sv ----
// Quarter-bit timebase for the serial clock divider.
// Assumes the divide count fits the package counter width.
`timescale 1ns/1ns
module tws_tick #(
  parameter int DIV = tws_pkg::QUARTER_CYC
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // One-cycle pulse every DIV cycles
  output logic o_tick
);

  tws_pkg::tws_tick_s s;
  tws_pkg::tws_tick_s n;

  // Free-running count; a stall of the user side never skews it
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.count == tws_pkg::TICK_W'(DIV - 1)) begin
      n.count = '0;
      n.tick = 1'b1;
    end else begin
      n.count = s.count + tws_pkg::TICK_W'(1);
    end
  end

  // Register the state, frozen while the enable is low
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= n;
    end
  end

  assign o_tick = s.tick;

endmodule

// ---- tb/tws_master_properties.sv ----
// Checker for the two-wire bus master, bound to its top module.
// Sees only the master's ports; one clock domain.
`timescale 1ns/1ns
module tws_master_properties #(
  parameter int QUARTER = tws_pkg::QUARTER_CYC
) (
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  // Watched outputs
  input wire logic o_cmd_ready,
  input wire logic o_done,
  input wire logic o_nack,
  input wire logic o_busy,
  input wire logic o_rdata_valid,
  input wire logic o_serial_clock,
  input wire logic o_serial_bus_line,
  input wire logic o_serial_bus_line_oe
);
  localparam int QW = QUARTER + 1;
  localparam int QT = 4 * QUARTER + 2;
  localparam int QS = 4 * QUARTER + 4;
  localparam int QN = 8 * QUARTER;
  logic [7:0] low_cnt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // Cycles of low serial clock; a long count beats a deep repetition
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || o_serial_clock) begin
      low_cnt <= 8'h00;
    end else if (i_ce) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  AST_IDLE_BUS: assert property (
    !o_busy && !$past(o_busy) |-> o_serial_clock && !o_serial_bus_line_oe)
    else $error("bus not idle high while master idle");
  AST_PULL_ONLY: assert property (
    o_serial_bus_line_oe |-> o_serial_bus_line == 1'b0)
    else $error("data line driven high");
  AST_START_HIGH: assert property (
    $rose(o_serial_bus_line_oe) && o_serial_clock |-> $past(o_serial_clock))
    else $error("start edge not inside clock high");
  AST_STOP_HIGH: assert property (
    $fell(o_serial_bus_line_oe) && o_serial_clock |-> $past(o_serial_clock))
    else $error("stop edge not inside clock high");
  AST_START_FALL: assert property (
    $rose(o_serial_bus_line_oe) && o_serial_clock
    |-> ##[1:QW] !o_serial_clock)
    else $error("clock did not fall after start");
  AST_STOP_DONE: assert property (
    $fell(o_serial_bus_line_oe) && o_serial_clock
    |-> o_serial_clock throughout (##[0:QS] o_done))
    else $error("no done after stop");
  AST_LOW_TIME: assert property (
    $rose(o_serial_clock) |-> low_cnt == 8'(2 * QUARTER))
    else $error("clock low phase length wrong");
  AST_TAKE_START: assert property (
    i_ce && i_cmd_valid && o_cmd_ready
    |-> ##[2:QT] ($rose(o_serial_bus_line_oe) && o_serial_clock))
    else $error("no start after command");
  AST_NACK_STOP: assert property (
    $rose(o_nack) |-> ##[1:QN] o_done)
    else $error("no stop after refused byte");

  // Main scenarios reached
  C_WRITE: cover property (o_done && !o_nack);
  C_READ: cover property (o_rdata_valid);
  C_NACK: cover property ($rose(o_nack));
endmodule

// ---- tb/tws_slave_model.sv ----
// Behavioural sensor slave on the two-wire bus, 16-bit pointer.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module tws_slave_model (
  // Bus side
  input wire logic i_scl,
  input wire logic i_sda,
  // Address select from the input pad
  input wire logic i_pad_sel,
  // High pulls data low; no clock output, never stretches
  output logic o_pull
);
  typedef enum logic [2:0] {
    PH_ADR, PH_AHI, PH_ALO, PH_WD, PH_RD, PH_OFF
  } tws_ph_e;
  tws_ph_e ph = PH_OFF;
  logic [7:0] mem [256];
  logic [7:0] sh = 8'h00;
  logic [7:0] prog = 8'h00;
  logic [15:0] ptr = 16'h0000;
  logic [3:0] bitc = 4'h0;
  logic fresh = 1'b0;
  logic ack;

  // Memory only keyed by the low pointer byte, to stay small
  initial begin
    o_pull = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~8'(i);
    end
  end

  // Start or restart re-arms decode; stop parks the model
  always @(negedge i_sda) begin
    if (i_scl) begin
      ph = PH_ADR;
      bitc = 4'h0;
      fresh = 1'b1;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl) ph = PH_OFF;
  end

  // Rising clock: take a bit, or the master's answer to a read byte
  always @(posedge i_scl) begin
    if (bitc == 4'h8) begin
      if (ph == PH_RD && i_sda) ph = PH_OFF;
    end else if (ph != PH_RD) begin
      sh = {sh[6:0], i_sda};
    end
  end

  // Falling clock: the only moment this side changes the line
  always @(negedge i_scl) begin
    if (fresh || ph == PH_OFF) begin
      fresh = 1'b0;
      o_pull = 1'b0;
    end else begin
      bitc = bitc + 4'h1;
      if (bitc == 4'h8) begin
        ack = ph != PH_RD;
        case (ph)
          PH_ADR: begin
            if ({sh[7:1], 1'b0} == (i_pad_sel ? 8'h6E : 8'h6C) ||
                {sh[7:1], 1'b0} == {prog[7:1], 1'b0}) begin
              ph = sh[0] ? PH_RD : PH_AHI;
            end else begin
              ph = PH_OFF;
              ack = 1'b0;
            end
          end
          PH_AHI: begin
            ptr[15:8] = sh;
            ph = PH_ALO;
          end
          PH_ALO: begin
            ptr[7:0] = sh;
            ph = PH_WD;
          end
          PH_WD: begin
            mem[ptr[7:0]] = sh;
            if (ptr == 16'h31FC) prog = sh;
            ptr = ptr + 16'h0001;
          end
          default: ;
        endcase
        o_pull = ack;
      end else if (bitc == 4'h9) begin
        bitc = 4'h0;
        o_pull = 1'b0;
        if (ph == PH_RD) begin
          sh = mem[ptr[7:0]];
          ptr = ptr + 16'h0001;
          o_pull = ~sh[7];
        end
      end else if (ph == PH_RD) begin
        o_pull = ~sh[3'(4'h7 - bitc)];
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Top bench: master against a behavioural slave on a pulled-up wire.
// Assumes the checker and slave model are compiled before it.
`timescale 1ns/1ns
module testbench;
  localparam int Q = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  tws_pkg::tws_cmd_s cmd = '0;
  logic wvalid = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic pad = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rdata;
  logic rvalid, ready, wready, done, nack, busy, scl, sda_o, oe, pull;
  wire sda = ~(oe | pull);  // Pull-up unless a party pulls
  int fail_count = 0;
  int compares = 0;

  // 25 MHz system clock
  always #20 mclk = ~mclk;

  tws_master #(.QUARTER(Q)) i_dut (
    .i_mclk(mclk), .i_reset_n(rst_n), .i_ce(ce),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(ready),
    .i_wdata_valid(wvalid), .i_wdata(wdata), .o_wdata_ready(wready),
    .o_rdata(rdata), .o_rdata_valid(rvalid), .o_done(done),
    .o_nack(nack), .o_busy(busy), .o_serial_clock(scl),
    .i_serial_bus_line(sda), .o_serial_bus_line(sda_o),
    .o_serial_bus_line_oe(oe));
  tws_slave_model i_slave (
    .i_scl(scl), .i_sda(sda), .i_pad_sel(pad), .o_pull(pull));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One transfer: d holds bytes to send, or bytes expected back
  task automatic run(input tws_pkg::tws_kind_e kd,
    input tws_pkg::tws_sel_e sl, input logic [6:0] pa,
    input logic [15:0] ra, input logic [7:0] d[$], input logic nk);
    int k;
    int n;
    int t;
    logic tk;
    k = 0;
    n = 0;
    tk = 1'b0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = '{kd, sl, pa, ra, 8'(d.size() - 1)};
    @(negedge mclk);
    cmd_valid = 1'b0;
    for (t = 0; t < 20000; t++) begin
      @(negedge mclk);
      if (tk) k++;
      if (rvalid) begin
        chk(rdata, d[n]);
        n++;
      end
      if (done) break;
      wvalid = (kd == tws_pkg::KIND_WRITE) && (k < d.size());
      wdata = wvalid ? d[k] : 8'h00;
      tk = wvalid && wready;
    end
    wvalid = 1'b0;
    if (t == 20000) begin
      fail_count++;
      finish_test();
    end
    chk(nack, nk);
    chk(16'(n + k), nk ? 16'h0000 : 16'(d.size()));
  endtask

  // Sequential write, then random read of the same bytes
  task automatic t_write_back();
    run(tws_pkg::KIND_WRITE, tws_pkg::SEL_DEFAULT, 7'h00, 16'h0010,
      '{8'h11, 8'h22, 8'h33}, 1'b0);
    run(tws_pkg::KIND_READ_RND, tws_pkg::SEL_DEFAULT, 7'h00, 16'h0010,
      '{8'h11, 8'h22, 8'h33}, 1'b0);
  endtask

  // Current read picks up where the last read stopped; the enable is
  // dropped mid-byte, and both pins must hold still while it is low
  task automatic t_current();
    logic [1:0] held;
    fork
      run(tws_pkg::KIND_READ_CUR, tws_pkg::SEL_DEFAULT, 7'h00, 16'h0000,
        '{8'hEC, 8'hEB}, 1'b0);
      begin
        repeat (100) @(negedge mclk);
        ce = 1'b0;
        held = {scl, oe};
        repeat (40) begin
          @(negedge mclk);
          chk({14'h0000, scl, oe}, {14'h0000, held});
        end
        ce = 1'b1;
      end
    join
  endtask

  // Pad select moves the answering address
  task automatic t_pad();
    run(tws_pkg::KIND_READ_CUR, tws_pkg::SEL_ALT, 7'h00, 16'h0000,
      '{8'h00}, 1'b1);
    pad = 1'b1;
    run(tws_pkg::KIND_READ_CUR, tws_pkg::SEL_DEFAULT, 7'h00, 16'h0000,
      '{8'h00}, 1'b1);
    run(tws_pkg::KIND_READ_CUR, tws_pkg::SEL_ALT, 7'h00, 16'h0000,
      '{8'hEA}, 1'b0);
    pad = 1'b0;
  endtask

  // Programmed alternate address answers after being set
  task automatic t_prog();
    run(tws_pkg::KIND_WRITE, tws_pkg::SEL_DEFAULT, 7'h00, 16'h31FC,
      '{8'h84}, 1'b0);
    run(tws_pkg::KIND_READ_CUR, tws_pkg::SEL_PROG, 7'h42, 16'h0000,
      '{8'h02}, 1'b0);
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk({12'h000, scl, oe, busy, ready}, 16'h0009);
    t_write_back();
    t_current();
    t_pad();
    t_prog();
    finish_test();
  end
endmodule

bind tws_master tws_master_properties #(.QUARTER(QUARTER)) u_props (
  .i_mclk, .i_reset_n, .i_ce, .i_cmd_valid, .o_cmd_ready, .o_done,
  .o_nack, .o_busy, .o_rdata_valid, .o_serial_clock, .o_serial_bus_line,
  .o_serial_bus_line_oe);
